// ---- design/led_driver_bus_front_end.sv ----
// Functional notes
// - Broadcast address matched only while broadcast enable bit is 1.
// - Broadcast match uses upper seven bits; lowest bit reserved, written zero.
// - Broadcast address register is writable over the bus like others.
// - Output-enable pin low enables LEDs; high puts all LEDs high impedance.
// - Power-on reset initialises all registers and bus walker.
// - Address 06h with write bit starts a software-reset call.
// - Software-reset address with read bit causes no action.
// - Software-reset keys are A5h then 5Ah, checked in order.
// - Bytes after the second key byte are ignored.
// - STOP after both correct keys resets everything; bus ready at once.
// - Reset state is standby, oscillator off; 500 us start-up after wake.
// - Eight channels, each 97 kHz PWM with 8-bit duty.
// - Group dimming superimposes 190 Hz PWM with 8-bit duty.
// - Group blinking period (n+1)/24 s, 8-bit duty.
// - One group signal at a time, applied to all eight outputs.
// - Receive-only slave; data line never driven.
// - Detect START and STOP on data edges while clock high.
// - Ninth clock per byte carries a 1; any byte count accepted.
// - Sub-call addresses matched only when their enables are set.
// - Update timing bit: buffered regs apply at STOP or ninth clock.
// - State field: 00 off, 01 on, 10 PWM, 11 PWM plus group.
`timescale 1ns/1ps
module led_driver_bus_front_end
	import led_front_pkg::*;
(
	input wire logic clk_sys, // System clock, 125 MHz
	input wire logic rst, // Synchronous reset, power-on
	input wire logic bus_clk, // Two-wire bus clock pin
	input wire logic bus_data, // Two-wire bus data pin
	input wire logic [5:0] hw_addr, // Hardware address pins
	input wire logic output_enable_n, // Active-low output enable pin
	output logic [7:0] led_low, // LED sink drive, high sinks current
	output logic [7:0] led_oe, // LED pin driver enable
	output logic osc_running // Oscillator up after start-up
);
	logic [1:0] clk_sync, data_sync, oe_sync;
	logic clk_q, data_q;
	logic [5:0] hw_meta, hw_pins;
	always_ff @(posedge clk_sys)
	begin
		clk_sync <= {clk_sync[0], bus_clk};
		data_sync <= {data_sync[0], bus_data};
		oe_sync <= {oe_sync[0], output_enable_n};
		hw_meta <= hw_addr;
		hw_pins <= hw_meta;
		clk_q <= clk_sync[1];
		data_q <= data_sync[1];
	end
	wire scl = clk_sync[1];
	wire sda = data_sync[1];
	wire start_det = scl && clk_q && data_q && !sda;
	wire stop_det = scl && clk_q && !data_q && sda;
	wire scl_rise = scl && !clk_q;

	// Registers: live copy and applied copy
	logic [7:0] primary, secondary, broadcast_address;
	logic [7:0] sub_addr [3];
	logic [7:0] bright_pend [8], bright [8];
	logic [7:0] gduty_act, gfreq_act;
	logic [15:0] state_pend, led_state_register;
	logic [7:0] gduty_pend, gfreq_pend;

	bus_state_e state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] reg_ptr;
	logic soft_key_ok, pend_dirty, soft_rst, key1_seen;
	wire byte_done = scl_rise && bit_cnt == 4'd8;
	wire ninth = byte_done;
	wire [7:0] rx_byte = shift;
	wire [6:0] own_addr = {1'b1, hw_pins};
	wire bcast_hit = rx_byte[7:1] == broadcast_address[7:1];
	wire bcast_ok = bcast_hit && primary[BIT_BCAST_EN];
	wire sub_ok = (rx_byte[7:1] == sub_addr[0][7:1] && primary[BIT_SUB1_EN])
		|| (rx_byte[7:1] == sub_addr[1][7:1] && primary[BIT_SUB2_EN])
		|| (rx_byte[7:1] == sub_addr[2][7:1] && primary[BIT_SUB3_EN]);
	wire write_bit = !rx_byte[0];
	wire addr_match = write_bit && (rx_byte[7:1] == own_addr || bcast_ok || sub_ok);
	// soft reset call; read direction ignored
	wire soft_call = rx_byte == SOFT_RESET_ADDR;
	wire write_byte = ninth && state == BUS_DATA;
	wire [7:0] ptr_next = reg_ptr == REG_LAST ? 8'h00 : reg_ptr + 8'h01;
	wire update_on_ack = secondary[BIT_UPDATE_SEL];
	// Byte lands first, applies next cycle
	logic ack_apply;
	always_ff @(posedge clk_sys)
	begin
		if (rst || soft_rst)
			ack_apply <= 1'b0;
		else
			ack_apply <= write_byte && update_on_ack;
	end
	// buffered registers apply at ninth clock or stop
	wire apply_now = ack_apply || (stop_det && pend_dirty);

	// nine clocks per byte, unlimited bytes
	always_ff @(posedge clk_sys)
	begin
		if (rst || soft_rst || start_det)
			bit_cnt <= 4'd0;
		else if (byte_done)
			bit_cnt <= 4'd0;
		else if (scl_rise && state != BUS_IDLE)
			bit_cnt <= bit_cnt + 4'd1;
	end
	always_ff @(posedge clk_sys)
	begin
		if (scl_rise && bit_cnt < 4'd8)
			shift <= {shift[6:0], sda};
	end

	// Bus walker
	always_ff @(posedge clk_sys)
	begin
		soft_rst <= 1'b0;
		if (rst || soft_rst)
		begin
			state <= BUS_IDLE;
			soft_key_ok <= 1'b0;
			reg_ptr <= 8'h00;
		end
		else if (stop_det)
		begin
			// stop after both keys resets device
			soft_rst <= state == BUS_IGNORE && soft_key_ok;
			state <= BUS_IDLE;
		end
		else if (start_det)
		begin
			state <= BUS_ADDR;
			soft_key_ok <= 1'b0;
		end
		else if (byte_done)
		begin
			case (state)
				BUS_ADDR:
					if (soft_call)
						state <= BUS_SOFT;
					else if (addr_match)
						state <= BUS_REGSEL;
					else
						state <= BUS_IGNORE;
				BUS_REGSEL:
				begin
					reg_ptr <= rx_byte;
					state <= BUS_DATA;
				end
				// keys checked in order; later bytes ignored
				BUS_SOFT:
					if (!key1_seen && rx_byte == SOFT_KEY1)
						state <= BUS_SOFT;
					else
					begin
						soft_key_ok <= key1_seen && rx_byte == SOFT_KEY2;
						state <= BUS_IGNORE;
					end
				BUS_DATA:
					reg_ptr <= ptr_next;
				default:
					state <= state;
			endcase
		end
	end
	// First key seen within this call
	always_ff @(posedge clk_sys)
	begin
		if (rst || soft_rst || start_det)
			key1_seen <= 1'b0;
		else if (byte_done && state == BUS_SOFT && rx_byte == SOFT_KEY1)
			key1_seen <= 1'b1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst || soft_rst)
		begin
			primary <= RST_PRIMARY;
			secondary <= RST_SECONDARY;
			gduty_pend <= RST_GROUP_DUTY;
			gfreq_pend <= 8'h00;
			state_pend <= 16'h0000;
			sub_addr[0] <= RST_SUB1;
			sub_addr[1] <= RST_SUB2;
			sub_addr[2] <= RST_SUB3;
			broadcast_address <= RST_BROADCAST;
			pend_dirty <= 1'b0;
		end
		else
		begin
			if (apply_now)
				pend_dirty <= 1'b0;
			if (write_byte)
			begin
				if (reg_ptr >= REG_BRIGHT0 && reg_ptr <= REG_LAST_BUFFERED)
					pend_dirty <= 1'b1;
				if (reg_ptr == REG_PRIMARY)
					primary <= rx_byte;
				else if (reg_ptr == REG_SECONDARY)
					secondary <= rx_byte;
				else if (reg_ptr == REG_GROUP_DUTY)
					gduty_pend <= rx_byte;
				else if (reg_ptr == REG_GROUP_FREQ)
					gfreq_pend <= rx_byte;
				else if (reg_ptr == REG_STATE0)
					state_pend[7:0] <= rx_byte;
				else if (reg_ptr == REG_STATE1)
					state_pend[15:8] <= rx_byte;
				else if (reg_ptr >= REG_SUB1 && reg_ptr < REG_BROADCAST)
					sub_addr[reg_ptr[1:0] - 2'd2] <= rx_byte;
				else if (reg_ptr == REG_BROADCAST)
					broadcast_address <= rx_byte;
			end
		end
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst || soft_rst)
		begin
			gduty_act <= RST_GROUP_DUTY;
			gfreq_act <= 8'h00;
			led_state_register <= 16'h0000;
		end
		else if (apply_now)
		begin
			gduty_act <= gduty_pend;
			gfreq_act <= gfreq_pend;
			led_state_register <= state_pend;
		end
	end

	// oscillator off in standby, start-up delay on wake
	logic [16:0] osc_cnt;
	wire sleeping = primary[BIT_SLEEP];
	always_ff @(posedge clk_sys)
	begin
		if (rst || soft_rst || sleeping)
			osc_cnt <= 17'd0;
		else if (osc_cnt != 17'(OSC_START_CYC))
			osc_cnt <= osc_cnt + 17'd1;
	end
	assign osc_running = osc_cnt == 17'(OSC_START_CYC);

	// Step enables for the PWM counters
	logic [3:0] pwm_div;
	logic [15:0] dim_div;
	logic [18:0] blink_div;
	logic [7:0] pwm_ph, dim_ph, blink_ph, blink_sub;
	wire pwm_step = osc_running && pwm_div == 4'(PWM_STEP_CYC - 1);
	wire dim_step = osc_running && dim_div == 16'(DIM_STEP_CYC - 1);
	wire blink_step = osc_running && blink_div == 19'(BLINK_STEP_CYC - 1);
	always_ff @(posedge clk_sys)
	begin
		if (rst || !osc_running)
		begin
			pwm_div <= 4'd0;
			dim_div <= 16'd0;
			blink_div <= 19'd0;
			pwm_ph <= 8'h00;
			dim_ph <= 8'h00;
			blink_ph <= 8'h00;
			blink_sub <= 8'h00;
		end
		else
		begin
			pwm_div <= pwm_step ? 4'd0 : pwm_div + 4'd1;
			dim_div <= dim_step ? 16'd0 : dim_div + 16'd1;
			blink_div <= blink_step ? 19'd0 : blink_div + 19'd1;
			if (pwm_step)
				pwm_ph <= pwm_ph + 8'h01;
			if (dim_step)
				dim_ph <= dim_ph + 8'h01;
			if (blink_step)
			begin
				blink_sub <= blink_sub == gfreq_act ? 8'h00 : blink_sub + 8'h01;
				if (blink_sub == gfreq_act)
					blink_ph <= blink_ph + 8'h01;
			end
		end
	end
	// one group signal for all channels
	wire group_on = secondary[BIT_BLINK_SEL] ? blink_ph < gduty_act : dim_ph < gduty_act;

	genvar ch;
	generate
		for (ch = 0; ch < 8; ch++)
		begin : g_ch
			wire [1:0] led_state_field = led_state_register[2*ch+1:2*ch];
			always_ff @(posedge clk_sys)
			begin
				if (rst || soft_rst)
					bright_pend[ch] <= 8'h00;
				else if (write_byte && reg_ptr == REG_BRIGHT0 + 8'(ch))
					bright_pend[ch] <= rx_byte;
			end
			always_ff @(posedge clk_sys)
			begin
				if (rst || soft_rst)
					bright[ch] <= 8'h00;
				else if (apply_now)
					bright[ch] <= bright_pend[ch];
			end
			wire indiv_on = pwm_ph < bright[ch];
			wire lit = led_state_field == 2'b01 ? 1'b1 :
				led_state_field == 2'b10 ? indiv_on :
				led_state_field == 2'b11 ? indiv_on && group_on : 1'b0;
			always_ff @(posedge clk_sys)
			begin
				if (rst)
					led_low[ch] <= 1'b0;
				else
					led_low[ch] <= lit;
			end
			assign led_oe[ch] = !oe_sync[1] && led_low[ch];
		end
	endgenerate
endmodule : led_driver_bus_front_end

// ---- design/led_front_pkg.sv ----
package led_front_pkg;
	// Register indices (address byte after slave address)
	localparam logic [7:0] REG_PRIMARY = 8'h00;
	localparam logic [7:0] REG_SECONDARY = 8'h01;
	localparam logic [7:0] REG_BRIGHT0 = 8'h02;
	localparam logic [7:0] REG_GROUP_DUTY = 8'h0A;
	localparam logic [7:0] REG_GROUP_FREQ = 8'h0B;
	localparam logic [7:0] REG_STATE0 = 8'h0C;
	localparam logic [7:0] REG_STATE1 = 8'h0D;
	localparam logic [7:0] REG_SUB1 = 8'h0E;
	localparam logic [7:0] REG_BROADCAST = 8'h11;
	localparam logic [7:0] REG_LAST = 8'h11;
	localparam logic [7:0] REG_LAST_BUFFERED = 8'h0D;
	// Reset values
	localparam logic [7:0] RST_PRIMARY = 8'h11;
	localparam logic [7:0] RST_SECONDARY = 8'h05;
	localparam logic [7:0] RST_GROUP_DUTY = 8'hFF;
	localparam logic [7:0] RST_SUB1 = 8'hE2;
	localparam logic [7:0] RST_SUB2 = 8'hE4;
	localparam logic [7:0] RST_SUB3 = 8'hE8;
	localparam logic [7:0] RST_BROADCAST = 8'hE0;
	// Field positions
	localparam int BIT_SLEEP = 4;
	localparam int BIT_SUB1_EN = 3;
	localparam int BIT_SUB2_EN = 2;
	localparam int BIT_SUB3_EN = 1;
	localparam int BIT_BCAST_EN = 0;
	localparam int BIT_BLINK_SEL = 5;
	localparam int BIT_UPDATE_SEL = 3;
	// Soft reset call
	localparam logic [7:0] SOFT_RESET_ADDR = 8'h06;
	localparam logic [7:0] SOFT_KEY1 = 8'hA5;
	localparam logic [7:0] SOFT_KEY2 = 8'h5A;
	// Timing
	localparam int CLK_MHZ = 125;
	localparam int OSC_START_US = 500;
	localparam int OSC_START_CYC = OSC_START_US * CLK_MHZ;
	localparam int PWM_KHZ = 97;
	localparam int PWM_STEP_CYC = (CLK_MHZ * 1000) / (PWM_KHZ * 256);
	localparam int DIM_HZ = 190;
	localparam int DIM_STEP_CYC = (CLK_MHZ * 1000000) / (DIM_HZ * 256);
	localparam int BLINK_HZ = 24;
	localparam int BLINK_STEP_CYC = (CLK_MHZ * 1000000) / (BLINK_HZ * 256);
	// Bus walker states
	typedef enum logic [2:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_REGSEL,
		BUS_DATA,
		BUS_SOFT,
		BUS_IGNORE
	} bus_state_e;
endpackage : led_front_pkg

// ---- verif/led_front_asserts.sv ----
`timescale 1ns/1ps
module led_front_asserts
	import led_front_pkg::*;
(
	input wire logic clk_sys, // clock
	input wire logic rst, // reset
	input wire logic bus_clk, // bus clock
	input wire logic bus_data, // bus data
	input wire logic [5:0] hw_addr, // address pins
	input wire logic output_enable_n, // enable pin
	input wire logic [7:0] led_low, // sink drive
	input wire logic [7:0] led_oe, // driver enable
	input wire logic osc_running // oscillator up
);
	logic bclk_q;
	logic bdat_q;
	logic seen_bus;
	logic [16:0] act_cnt;
	logic [4:0] idle_cnt;
	wire bus_edge = (bus_clk != bclk_q) || (bus_data != bdat_q);
	always_ff @(posedge clk_sys)
	begin
		bclk_q <= bus_clk;
		bdat_q <= bus_data;
		seen_bus <= !rst && (seen_bus || bus_edge);
		act_cnt <= (rst || !seen_bus) ? '0 : act_cnt + 17'(act_cnt != '1);
		idle_cnt <= (rst || bus_edge) ? '0 : idle_cnt + 5'(idle_cnt != '1);
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_oe_off; output_enable_n [*5] |-> led_oe == 8'h00; endproperty
	property p_oe_rise; $rose(output_enable_n) |-> ##[1:5] led_oe == 8'h00; endproperty
	property p_rel_leds; $fell(rst) |-> led_low == 8'h00; endproperty
	property p_rel_osc; $fell(rst) |-> !osc_running; endproperty
	property p_quiet_leds; !seen_bus |-> led_low == 8'h00; endproperty
	property p_quiet_osc; !seen_bus |-> !osc_running; endproperty
	property p_osc_time; $rose(osc_running) |-> act_cnt >= 17'(OSC_START_CYC); endproperty
	property p_osc_fall; $fell(osc_running) |-> idle_cnt < 5'd20; endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("leds driven while enable pin high");
	a_oe_rise: assert property (p_oe_rise)
		else $error("leds not released after enable pin rose");
	a_rel_leds: assert property (p_rel_leds)
		else $error("leds lit after reset");
	a_rel_osc: assert property (p_rel_osc)
		else $error("oscillator up after reset");
	a_quiet_leds: assert property (p_quiet_leds)
		else $error("leds lit without bus traffic");
	a_quiet_osc: assert property (p_quiet_osc)
		else $error("oscillator up without bus traffic");
	a_osc_time: assert property (p_osc_time)
		else $error("oscillator up too early");
	a_osc_fall: assert property (p_osc_fall)
		else $error("oscillator stopped without bus cause");
	c_osc: cover property ($rose(osc_running));
	c_lit: cover property (led_low != 8'h00);
	c_oe: cover property ($rose(output_enable_n));
endmodule : led_front_asserts

bind led_driver_bus_front_end led_front_asserts u_asserts (
	.clk_sys(clk_sys), .rst(rst), .bus_clk(bus_clk), .bus_data(bus_data),
	.hw_addr(hw_addr), .output_enable_n(output_enable_n), .led_low(led_low),
	.led_oe(led_oe), .osc_running(osc_running)
);

// ---- verif/bus_master.sv ----
`timescale 1ns/1ps
module bus_master (
	output logic scl, // bus clock
	output logic sda // bus data
);
	localparam time HALF = 32ns;
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic start_cond();
		#HALF;
		sda = 1'b0;
		#HALF;
		scl = 1'b0;
	endtask : start_cond
	task automatic put_byte(input logic [7:0] b);
		for (int i = 8; i >= 0; i--)
		begin
			#(HALF / 2);
			sda = (i == 0) ? 1'b1 : b[i - 1];
			#(HALF / 2);
			scl = 1'b1;
			#HALF;
			scl = 1'b0;
		end
	endtask : put_byte
	task automatic stop_cond();
		#(HALF / 2);
		sda = 1'b0;
		#(HALF / 2);
		scl = 1'b1;
		#HALF;
		sda = 1'b1;
		#HALF;
	endtask : stop_cond
endmodule : bus_master

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	import led_front_pkg::*;
	`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
		$display("Error %s expected %h seen %h", n, e, g); end end
	logic clk_sys;
	logic rst;
	logic bus_clk;
	logic bus_data;
	logic [5:0] hw_addr;
	logic output_enable_n;
	logic [7:0] led_low;
	logic [7:0] led_oe;
	logic osc_running;
	logic [7:0] own;
	logic [7:0] mask;
	int seed = 32'h529243e3;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;
	int hits;
	bus_master master (.scl(bus_clk), .sda(bus_data));
	led_driver_bus_front_end dut (
		.clk_sys(clk_sys), .rst(rst), .bus_clk(bus_clk), .bus_data(bus_data), .hw_addr(hw_addr),
		.output_enable_n(output_enable_n), .led_low(led_low), .led_oe(led_oe),
		.osc_running(osc_running)
	);
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Two bits per channel, 01 on, 00 off
	function automatic logic [23:0] states(input logic [7:0] m);
		states = '0;
		for (int i = 0; i < 8; i++)
			states[2 * i +: 2] = {1'b0, m[i]};
	endfunction : states
	task automatic wr(input logic [7:0] a, r, input logic [23:0] d, input int n, input bit fin);
		#2;
		master.start_cond();
		master.put_byte(a);
		master.put_byte(r);
		for (int i = 0; i < n; i++)
			master.put_byte(d[8 * i +: 8]);
		if (fin)
			master.stop_cond();
		repeat (16) @(posedge clk_sys);
	endtask : wr
	task automatic end_sim();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			miscompares++;
			end_sim();
		end
	end
	initial
	begin
		rst = 1'b1;
		output_enable_n = 1'b0;
		hw_addr = {1'b0, 5'($random(seed))};
		own = {1'b1, hw_addr, 1'b0};
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		`CHK("led_low", 8'h00, led_low)
		`CHK("osc_running", 1'b0, osc_running)
		mask = $random(seed);
		wr(own, REG_STATE0, states(mask), 2, 1);
		`CHK("led_low", mask, led_low)
		`CHK("led_oe", mask, led_oe)
		output_enable_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		`CHK("led_oe", 8'h00, led_oe)
		output_enable_n <= 1'b0;
		mask = $random(seed);
		wr(RST_BROADCAST, REG_STATE0, states(mask), 2, 1);
		`CHK("led_low", mask, led_low)
		wr(RST_SUB1, REG_STATE0, states(~mask), 2, 1);
		`CHK("led_low", mask, led_low)
		wr(own, REG_PRIMARY, {8'h00, RST_SECONDARY, 8'h18}, 2, 1);
		wr(RST_BROADCAST, REG_STATE0, states(~mask), 2, 1);
		`CHK("led_low", mask, led_low)
		wr(RST_SUB1, REG_STATE0, states(~mask), 2, 1);
		`CHK("led_low", ~mask, led_low)
		wr(own, REG_BROADCAST, {8'h00, RST_PRIMARY, 8'hC4}, 2, 1);
		wr(8'hC4, REG_STATE0, states(mask), 2, 1);
		`CHK("led_low", mask, led_low)
		wr(SOFT_RESET_ADDR | 8'h01, SOFT_KEY1, 24'(SOFT_KEY2), 1, 1);
		`CHK("led_low", mask, led_low)
		wr(SOFT_RESET_ADDR, SOFT_KEY2, 24'(SOFT_KEY1), 1, 1);
		`CHK("led_low", mask, led_low)
		wr(SOFT_RESET_ADDR, SOFT_KEY1, {16'hFFFF, SOFT_KEY2}, 3, 1);
		`CHK("led_low", 8'h00, led_low)
		wr(RST_BROADCAST, REG_STATE0, states(mask), 2, 1);
		`CHK("led_low", mask, led_low)
		wr(own, REG_STATE0, states(~mask), 2, 0);
		`CHK("led_low", mask, led_low)
		#2 master.stop_cond();
		repeat (16) @(posedge clk_sys);
		`CHK("led_low", ~mask, led_low)
		wr(own, REG_PRIMARY, {8'h00, 8'h0D, RST_PRIMARY}, 2, 1);
		wr(own, REG_STATE0, states(mask), 2, 0);
		`CHK("led_low", mask, led_low)
		#2 master.stop_cond();
		wr(own, REG_PRIMARY, 24'(8'h01), 1, 1);
		repeat (OSC_START_CYC - 50) @(posedge clk_sys);
		`CHK("osc_running", 1'b0, osc_running)
		repeat (200) @(posedge clk_sys);
		`CHK("osc_running", 1'b1, osc_running)
		wr(own, REG_BRIGHT0, 24'(8'h80), 1, 1);
		wr(own, REG_STATE0, 24'(8'h02), 1, 1);
		hits = 0;
		repeat (256 * PWM_STEP_CYC) @(negedge clk_sys) hits += int'(led_low[0]);
		`CHK("pwm_high", 128 * PWM_STEP_CYC, hits)
		// zero group duty blanks channel 0
		wr(own, REG_GROUP_DUTY, {8'h03, 16'h0000}, 3, 1);
		hits = 0;
		repeat (256 * PWM_STEP_CYC) @(negedge clk_sys) hits += int'(led_low[0]);
		`CHK("group_high", 0, hits)
		wr(SOFT_RESET_ADDR, SOFT_KEY1, 24'(SOFT_KEY2), 1, 1);
		`CHK("osc_running", 1'b0, osc_running)
		`CHK("led_low", 8'h00, led_low)
		end_sim();
	end
endmodule : testbench
